// file: hdl/sdr_pkg.sv
// shared constants of the squib diagnostic response decoder
// assumes one 20 MHz system clock and an 8-bit mode-0 serial link
package sdr_pkg;

   // ---------------------------------------------------------------
   // serial frame
   // ---------------------------------------------------------------
   localparam int unsigned FRAME_BITS = 8;
   localparam logic [3:0]  BIT_CNT_RST = 4'h0;
   localparam logic [3:0]  BIT_CNT_MAX = 4'hF;
   localparam logic [7:0]  RESP_RST    = 8'h00;

   // ---------------------------------------------------------------
   // diagnostic command codes
   // ---------------------------------------------------------------
   localparam logic [7:0] CMD_NO_OPERATION = 8'h00;
   localparam logic [7:0] CMD_TIME_1A      = 8'h70;
   localparam logic [7:0] CMD_TIME_1B      = 8'h71;
   localparam logic [7:0] CMD_TIME_2A      = 8'h72;
   localparam logic [7:0] CMD_TIME_2B      = 8'h73;
   localparam logic [7:0] CMD_CURR_LIMIT   = 8'h79;
   localparam logic [7:0] CMD_THERMAL      = 8'h7F;
   localparam logic [7:0] CMD_SUPPLY_SAFE  = 8'hC0;
   localparam logic [7:0] CMD_SHORT_CHECK  = 8'hC1;
   localparam logic [7:0] CMD_CONTINUITY   = 8'hC2;
   localparam logic [7:0] CMD_OPEN_SHORT   = 8'hC3;
   localparam logic [7:0] CMD_FIRE_SUPPLY  = 8'hC5;
   localparam logic [7:0] CMD_DIAG_LEVEL   = 8'hC6;

   // ---------------------------------------------------------------
   // register port map
   // ---------------------------------------------------------------
   localparam logic [3:0] REG_STATUS   = 4'h0;
   localparam logic [3:0] REG_MASK     = 4'h4;
   localparam logic [3:0] REG_LAST_CMD = 4'h8;
   localparam logic [3:0] REG_RESPONSE = 4'hC;

   localparam int unsigned EVT_CMD_DONE  = 0;
   localparam int unsigned EVT_UNKNOWN   = 1;
   localparam int unsigned EVT_FRAME_ERR = 2;

   localparam logic [7:0] STATUS_RST   = 8'h00;
   localparam logic [7:0] MASK_RST     = 8'h00;
   localparam logic [7:0] LAST_CMD_RST = 8'h00;

endpackage

// file: hdl/sdr_diag_decoder.sv
// diagnostic command decoder and response formatter of a four-channel squib driver
// assumes status inputs come from logic on clk_i; serial pins are asynchronous
//
// Added by the designer: the strobed register port and the address map.
`timescale 1ns/1ns

// Summary of operation
// - codes 70..73 return measurement time count of 1A, 1B, 2A, 2B, msb first.
// - code 79 returns current-limit flags 2B..1A in bits 3..0, upper nibble zero.
// - code 7F returns thermal flags per channel pair, low side upper, high side lower.
// - code C0 returns safing low, safing high, supply high, supply low per supply.
// - code C1 returns no-ground-short upper, no-battery-short lower, pairs 2B..1A.
// - code C2 returns low-side continuity flags 2B..1A in bits 3..0, upper zero.
// - code C3 returns open-squib harness short flags in the same pair layout.
// - code C5 returns tested in bit 4, high in bit 1, low in bit 0.
// - code C6 returns supply 2 levels in bits 7..4, supply 1 levels in 3..0.
// - each transfer shifts out the answer to the previous command.
module sdr_diag_decoder
   import sdr_pkg::*;
(
   // clock and reset
   input  wire logic             clk_i,
   input  wire logic             sys_rst_i,
   // serial link from host
   input  wire logic             spi_sclk_i,
   input  wire logic             spi_cs_n_i,
   input  wire logic             spi_mosi_i,
   output logic                  spi_miso_o,
   output logic                  spi_miso_oe_o,
   // measurement and diagnostic status, index 0 = 1A .. 3 = 2B
   input  wire logic [3:0][7:0]  meas_time_i,
   input  wire logic [3:0]       current_limit_i,
   input  wire logic [3:0]       low_side_thermal_flag_i,
   input  wire logic [3:0]       high_side_thermal_flag_i,
   input  wire logic [3:0]       no_ground_short_flag_i,
   input  wire logic [3:0]       no_battery_short_flag_i,
   input  wire logic [3:0]       open_no_ground_short_flag_i,
   input  wire logic [3:0]       open_no_battery_short_flag_i,
   input  wire logic [3:0]       continuity_flag_i,
   // supply status, index 0 = supply 1, 1 = supply 2
   input  wire logic [1:0]       safing_resistance_low_flag_i,
   input  wire logic [1:0]       safing_resistance_high_flag_i,
   input  wire logic [1:0]       diag_supply_high_flag_i,
   input  wire logic [1:0]       diag_supply_low_flag_i,
   input  wire logic [1:0][3:0]  diagnostic_supply_level_i,
   input  wire logic             firing_supply_tested_i,
   input  wire logic             firing_supply_high_i,
   input  wire logic             firing_supply_low_i,
   // register port
   input  wire logic [3:0]       reg_addr_i,
   input  wire logic [7:0]       reg_wdata_i,
   input  wire logic             reg_wr_i,
   input  wire logic             reg_rd_i,
   output logic      [7:0]       reg_rdata_o,
   // interrupt
   output logic                  irq_o
);

   import sdr_pkg::*;

   // ---------------------------------------------------------------
   // pin synchronisers
   // ---------------------------------------------------------------
   logic [2:0] sclk_sync_ff;
   logic [2:0] cs_n_sync_ff;
   logic [1:0] mosi_sync_ff;

   // third stage only remembers the settled level for edge finding
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         sclk_sync_ff <= 3'b000;
         cs_n_sync_ff <= 3'b111;
         mosi_sync_ff <= 2'b00;
      end else begin
         sclk_sync_ff <= {sclk_sync_ff[1:0], spi_sclk_i};
         cs_n_sync_ff <= {cs_n_sync_ff[1:0], spi_cs_n_i};
         mosi_sync_ff <= {mosi_sync_ff[0], spi_mosi_i};
      end
   end

   logic sclk_rise;
   logic sclk_fall;
   logic cs_fall;
   logic cs_rise;

   assign sclk_rise = sclk_sync_ff[1] & ~sclk_sync_ff[2];
   assign sclk_fall = ~sclk_sync_ff[1] & sclk_sync_ff[2];
   assign cs_fall   = ~cs_n_sync_ff[1] & cs_n_sync_ff[2];
   assign cs_rise   = cs_n_sync_ff[1] & ~cs_n_sync_ff[2];

   // ---------------------------------------------------------------
   // frame shifter
   // ---------------------------------------------------------------
   logic       frame_ff;
   logic [3:0] bit_cnt_ff;
   logic [7:0] rx_ff;
   logic [7:0] tx_ff;
   logic [7:0] resp_ff;
   logic       decode_go;
   logic       frame_bad;

   // only a frame of exactly eight clocks is treated as a command
   assign decode_go = cs_rise & frame_ff & (bit_cnt_ff == 4'(FRAME_BITS));
   assign frame_bad = cs_rise & frame_ff & (bit_cnt_ff != 4'(FRAME_BITS));

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         frame_ff   <= 1'b0;
         bit_cnt_ff <= BIT_CNT_RST;
         rx_ff      <= RESP_RST;
         tx_ff      <= RESP_RST;
      end else if (cs_fall) begin
         frame_ff   <= 1'b1;
         bit_cnt_ff <= BIT_CNT_RST;
         tx_ff      <= resp_ff;
      end else if (cs_rise) begin
         frame_ff   <= 1'b0;
      end else if (frame_ff && sclk_rise) begin
         rx_ff      <= {rx_ff[6:0], mosi_sync_ff[1]};
         if (bit_cnt_ff != BIT_CNT_MAX) begin
            bit_cnt_ff <= bit_cnt_ff + 4'h1;
         end
      end else if (frame_ff && sclk_fall) begin
         tx_ff      <= {tx_ff[6:0], 1'b0};
      end
   end

   assign spi_miso_o    = tx_ff[7];
   assign spi_miso_oe_o = frame_ff;

   // ---------------------------------------------------------------
   // response formatter
   // ---------------------------------------------------------------
   logic [7:0] nxt_resp;
   logic       cmd_known;

   always_comb begin
      nxt_resp  = RESP_RST;
      cmd_known = 1'b1;
      case (rx_ff)
         CMD_NO_OPERATION: nxt_resp = RESP_RST;
         CMD_TIME_1A:      nxt_resp = meas_time_i[0];
         CMD_TIME_1B:      nxt_resp = meas_time_i[1];
         CMD_TIME_2A:      nxt_resp = meas_time_i[2];
         CMD_TIME_2B:      nxt_resp = meas_time_i[3];
         CMD_CURR_LIMIT:   nxt_resp = {4'h0, current_limit_i};
         CMD_THERMAL: begin
            for (int i = 0; i < 4; i++) begin
               nxt_resp[2*i+1] = low_side_thermal_flag_i[i];
               nxt_resp[2*i]   = high_side_thermal_flag_i[i];
            end
         end
         CMD_SUPPLY_SAFE: begin
            for (int s = 0; s < 2; s++) begin
               nxt_resp[4*s+3] = safing_resistance_low_flag_i[s];
               nxt_resp[4*s+2] = safing_resistance_high_flag_i[s];
               nxt_resp[4*s+1] = diag_supply_high_flag_i[s];
               nxt_resp[4*s]   = diag_supply_low_flag_i[s];
            end
         end
         CMD_SHORT_CHECK: begin
            for (int i = 0; i < 4; i++) begin
               nxt_resp[2*i+1] = no_ground_short_flag_i[i];
               nxt_resp[2*i]   = no_battery_short_flag_i[i];
            end
         end
         CMD_CONTINUITY:   nxt_resp = {4'h0, continuity_flag_i};
         CMD_OPEN_SHORT: begin
            for (int i = 0; i < 4; i++) begin
               nxt_resp[2*i+1] = open_no_ground_short_flag_i[i];
               nxt_resp[2*i]   = open_no_battery_short_flag_i[i];
            end
         end
         // don't-care bits 3:2 are driven low
         CMD_FIRE_SUPPLY:  nxt_resp = {3'b000, firing_supply_tested_i, 2'b00,
                                       firing_supply_high_i, firing_supply_low_i};
         CMD_DIAG_LEVEL:   nxt_resp = {diagnostic_supply_level_i[1],
                                       diagnostic_supply_level_i[0]};
         default: begin
            nxt_resp  = RESP_RST;
            cmd_known = 1'b0;
         end
      endcase
   end

   // snapshot taken at the end of the frame, so the host always sees one
   // coherent byte even if status inputs move during the next transfer
   logic [7:0] last_cmd_ff;

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         resp_ff     <= RESP_RST;
         last_cmd_ff <= LAST_CMD_RST;
      end else if (decode_go) begin
         resp_ff <= nxt_resp;
         if (rx_ff != CMD_NO_OPERATION) begin
            last_cmd_ff <= rx_ff;
         end
      end
   end

   // ---------------------------------------------------------------
   // event status, mask and interrupt
   // ---------------------------------------------------------------
   logic [7:0] status_ff;
   logic [7:0] mask_ff;
   logic [7:0] events;
   logic [7:0] nxt_status;
   logic [7:0] nxt_mask;
   logic       status_rd;

   always_comb begin
      events                = 8'h00;
      events[EVT_CMD_DONE]  = decode_go & (rx_ff != CMD_NO_OPERATION);
      events[EVT_UNKNOWN]   = decode_go & ~cmd_known;
      events[EVT_FRAME_ERR] = frame_bad;
   end

   assign status_rd  = reg_rd_i & (reg_addr_i == REG_STATUS);
   // a new event in the clearing cycle survives the clear
   assign nxt_status = (status_rd ? STATUS_RST : status_ff) | events;
   // a mask write counts at once, so irq never lags a mask change
   assign nxt_mask   = (reg_wr_i && reg_addr_i == REG_MASK) ? reg_wdata_i : mask_ff;

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         status_ff <= STATUS_RST;
      end else begin
         status_ff <= nxt_status;
      end
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         mask_ff <= MASK_RST;
      end else if (reg_wr_i && reg_addr_i == REG_MASK) begin
         mask_ff <= reg_wdata_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= |(nxt_status & nxt_mask);
      end
   end

   // ---------------------------------------------------------------
   // register read port
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         reg_rdata_o <= 8'h00;
      end else if (reg_rd_i) begin
         case (reg_addr_i)
            REG_STATUS:   reg_rdata_o <= status_ff;
            REG_MASK:     reg_rdata_o <= mask_ff;
            REG_LAST_CMD: reg_rdata_o <= last_cmd_ff;
            REG_RESPONSE: reg_rdata_o <= resp_ff;
            default:      reg_rdata_o <= 8'h00;
         endcase
      end else begin
         reg_rdata_o <= 8'h00;
      end
   end

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);

   sequence cmd_taken(logic [7:0] code);
      decode_go && rx_ff == code;
   endsequence

   sequence frame_open;
      cs_fall ##1 frame_ff;
   endsequence

   meas_time_a: assert property (cmd_taken(CMD_TIME_2A) |=> resp_ff == $past(meas_time_i[2]))
      else $error("time count of 2A not returned");
   curr_limit_a: assert property (cmd_taken(CMD_CURR_LIMIT) |=>
                                  resp_ff == {4'h0, $past(current_limit_i)})
      else $error("current limit byte wrong");
   thermal_pair_a: assert property (cmd_taken(CMD_THERMAL) |=>
                                    resp_ff[7] == $past(low_side_thermal_flag_i[3]) &&
                                    resp_ff[0] == $past(high_side_thermal_flag_i[0]))
      else $error("thermal pair layout wrong");
   supply_safe_a: assert property (cmd_taken(CMD_SUPPLY_SAFE) |=>
                                   resp_ff[7] == $past(safing_resistance_low_flag_i[1]) &&
                                   resp_ff[0] == $past(diag_supply_low_flag_i[0]))
      else $error("supply and safing byte wrong");
   short_check_a: assert property (cmd_taken(CMD_SHORT_CHECK) |=>
                                   resp_ff[1] == $past(no_ground_short_flag_i[0]) &&
                                   resp_ff[6] == $past(no_battery_short_flag_i[3]))
      else $error("short check byte wrong");
   continuity_a: assert property (cmd_taken(CMD_CONTINUITY) |=>
                                  resp_ff == {4'h0, $past(continuity_flag_i)})
      else $error("continuity byte wrong");
   open_short_a: assert property (cmd_taken(CMD_OPEN_SHORT) |=>
                                  resp_ff[3] == $past(open_no_ground_short_flag_i[1]) &&
                                  resp_ff[4] == $past(open_no_battery_short_flag_i[2]))
      else $error("open harness byte wrong");
   fire_supply_a: assert property (cmd_taken(CMD_FIRE_SUPPLY) |=>
                                   resp_ff[7:5] == 3'b000 && resp_ff[4] == $past(firing_supply_tested_i)
                                   && resp_ff[1:0] == $past({firing_supply_high_i, firing_supply_low_i}))
      else $error("firing supply byte wrong");
   diag_level_a: assert property (cmd_taken(CMD_DIAG_LEVEL) |=>
                                  resp_ff == $past({diagnostic_supply_level_i[1],
                                                    diagnostic_supply_level_i[0]}))
      else $error("supply level byte wrong");
   prev_answer_a: assert property (frame_open |-> tx_ff == $past(resp_ff) && spi_miso_oe_o)
      else $error("transfer does not carry previous answer");
   no_op_a: assert property (cmd_taken(CMD_NO_OPERATION) |=>
                             resp_ff == 8'h00 && $stable(last_cmd_ff) &&
                             status_ff[EVT_CMD_DONE] == ($past(status_ff[EVT_CMD_DONE]) && !$past(status_rd)))
      else $error("no-operation changed state");
   irq_level_a: assert property (irq_o == |(status_ff & mask_ff))
      else $error("interrupt level differs from unmasked status");

   // remaining time codes, frame errors, unknown codes and the register side
   time_1a_a: assert property (cmd_taken(CMD_TIME_1A) |=> resp_ff == $past(meas_time_i[0]))
      else $error("time count of 1A not returned");
   time_1b_a: assert property (cmd_taken(CMD_TIME_1B) |=> resp_ff == $past(meas_time_i[1]))
      else $error("time count of 1B not returned");
   time_2b_a: assert property (cmd_taken(CMD_TIME_2B) |=> resp_ff == $past(meas_time_i[3]))
      else $error("time count of 2B not returned");
   short_frame_a: assert property (frame_bad |=> $stable(resp_ff) && status_ff[EVT_FRAME_ERR])
      else $error("short frame disturbed the pending answer");
   unknown_zero_a: assert property (decode_go && !cmd_known |=> resp_ff == 8'h00 && status_ff[EVT_UNKNOWN])
      else $error("unknown code answer not zero");
   last_code_a: assert property (decode_go && rx_ff != CMD_NO_OPERATION |=> last_cmd_ff == $past(rx_ff))
      else $error("last code not recorded");
   mask_write_a: assert property (reg_wr_i && reg_addr_i == REG_MASK |=> mask_ff == $past(reg_wdata_i))
      else $error("mask write lost");
   rdata_idle_a: assert property (!reg_rd_i |=> reg_rdata_o == 8'h00)
      else $error("read data outside its cycle");
   status_set_a: assert property (events != 8'h00 |=> (status_ff & $past(events)) == $past(events))
      else $error("event lost against status clear");

endmodule

// file: testbench/sdr_host_model.sv
// host-side serial master for the squib diagnostic decoder bench
// assumes mode 0 framing, driven from the 50 ns bench clock
`timescale 1ns/1ns
module sdr_host_model (
   // clock
   input  wire logic clk_i,
   // serial link
   output logic      spi_sclk_o,
   output logic      spi_cs_n_o,
   output logic      spi_mosi_o,
   input  wire logic spi_miso_i
);
   initial begin
      spi_sclk_o = 1'b0;
      spi_cs_n_o = 1'b1;
      spi_mosi_o = 1'b0;
   end

   // ---------------------------------------------------------------
   // one frame; half = clk cycles per sclk phase (4 = 400 ns period)
   // ---------------------------------------------------------------
   task automatic xfer(input logic [7:0] tx, input int nbits, input int half, output logic [7:0] rx);
      rx = 8'h00;
      @(posedge clk_i);
      spi_cs_n_o <= 1'b0;
      spi_mosi_o <= tx[7];
      // setup of 300 ns also covers the first answer bit lag
      repeat (6) @(posedge clk_i);
      for (int i = 0; i < nbits; i++) begin
         spi_sclk_o <= 1'b1;
         rx = {rx[6:0], spi_miso_i};
         repeat (half) @(posedge clk_i);
         spi_sclk_o <= 1'b0;
         if (i < 7) begin
            spi_mosi_o <= tx[6 - i];
         end else begin
            spi_mosi_o <= ~tx[0];
         end
         repeat (half) @(posedge clk_i);
      end
      spi_cs_n_o <= 1'b1;
      // released line shows no stale bit
      spi_mosi_o <= ~spi_mosi_o;
      repeat (6) @(posedge clk_i);
   endtask
endmodule

// file: testbench/tb_top.sv
// self-checking bench of the squib diagnostic decoder
// assumes the host model drives the serial link; this module drives the rest
`timescale 1ns/1ns
module tb_top;
   import sdr_pkg::*;
   logic        clk_i;
   logic        sys_rst_i;
   logic        sclk, cs_n, mosi, miso, miso_oe, irq;
   logic [95:0] stim_ff;
   logic [3:0]  reg_addr;
   logic [7:0]  reg_wdata, reg_rdata, rx, prev, code, st;
   logic        reg_wr, reg_rd;
   int          err_count, samples_checked;
   logic [7:0]  codes [13] = '{CMD_TIME_1A, CMD_TIME_1B, CMD_TIME_2A, CMD_TIME_2B, CMD_CURR_LIMIT,
      CMD_THERMAL, CMD_SUPPLY_SAFE, CMD_SHORT_CHECK, CMD_CONTINUITY, CMD_OPEN_SHORT, CMD_FIRE_SUPPLY,
      CMD_DIAG_LEVEL, CMD_NO_OPERATION};

   sdr_diag_decoder dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .spi_sclk_i(sclk), .spi_cs_n_i(cs_n),
      .spi_mosi_i(mosi), .spi_miso_o(miso), .spi_miso_oe_o(miso_oe), .meas_time_i(stim_ff[31:0]),
      .current_limit_i(stim_ff[35:32]), .low_side_thermal_flag_i(stim_ff[39:36]),
      .high_side_thermal_flag_i(stim_ff[43:40]), .no_ground_short_flag_i(stim_ff[47:44]),
      .no_battery_short_flag_i(stim_ff[51:48]), .open_no_ground_short_flag_i(stim_ff[55:52]),
      .open_no_battery_short_flag_i(stim_ff[59:56]), .continuity_flag_i(stim_ff[63:60]),
      .safing_resistance_low_flag_i(stim_ff[65:64]), .safing_resistance_high_flag_i(stim_ff[67:66]),
      .diag_supply_high_flag_i(stim_ff[69:68]), .diag_supply_low_flag_i(stim_ff[71:70]),
      .diagnostic_supply_level_i(stim_ff[79:72]), .firing_supply_tested_i(stim_ff[80]),
      .firing_supply_high_i(stim_ff[81]), .firing_supply_low_i(stim_ff[82]), .reg_addr_i(reg_addr),
      .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata), .irq_o(irq));

   sdr_host_model host (.clk_i(clk_i), .spi_sclk_o(sclk), .spi_cs_n_o(cs_n), .spi_mosi_o(mosi),
      .spi_miso_i(miso));

   // ---------------------------------------------------------------
   // expected answer byte, worked out from the status inputs
   // ---------------------------------------------------------------
   function automatic logic [7:0] exp_resp(input logic [7:0] c, input logic [95:0] s);
      logic [7:0] r;
      r = 8'h00;
      for (int i = 0; i < 4; i++) begin
         case (c)
            CMD_THERMAL:     r[2*i +: 2] = {s[36+i], s[40+i]};
            CMD_SHORT_CHECK: r[2*i +: 2] = {s[44+i], s[48+i]};
            CMD_OPEN_SHORT:  r[2*i +: 2] = {s[52+i], s[56+i]};
            default:         r = r;
         endcase
      end
      case (c)
         CMD_TIME_1A, CMD_TIME_1B, CMD_TIME_2A, CMD_TIME_2B: r = s[8*c[1:0] +: 8];
         CMD_CURR_LIMIT:  r = {4'h0, s[35:32]};
         CMD_SUPPLY_SAFE: r = {s[65], s[67], s[69], s[71], s[64], s[66], s[68], s[70]};
         CMD_CONTINUITY:  r = {4'h0, s[63:60]};
         CMD_FIRE_SUPPLY: r = {3'b000, s[80], 2'b00, s[81], s[82]};
         CMD_DIAG_LEVEL:  r = s[79:72];
         default:         r = r;
      endcase
      return r;
   endfunction

   // ---------------------------------------------------------------
   // access tasks
   // ---------------------------------------------------------------
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_i);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk_i);
      reg_wr    <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge clk_i);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk_i);
      reg_rd   <= 1'b0;
      #1 d = reg_rdata;
   endtask

   task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp, input string what);
      logic [7:0] d;
      rd(a, d);
      chk(what, exp, d);
   endtask

   task automatic results();
      $display("comparisons %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   initial begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end

   // hang guard
   initial begin
      repeat (100000) @(posedge clk_i);
      err_count++;
      $display("[ERR] run length expected end seen timeout");
      results();
   end

   initial begin
      sys_rst_i = 1'b1;
      stim_ff = '0;
      reg_addr = 4'h0;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      err_count = 0;
      samples_checked = 0;
      repeat (2) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      // reset values, unmapped holes at even addresses read zero
      for (int a = 0; a < 16; a += 2) rd_chk(4'(a), 8'h00, "reset read");
      wr(REG_MASK, 8'h07);
      rd_chk(REG_MASK, 8'h07, "mask");
      wr(REG_STATUS, 8'hFF);
      rd_chk(REG_STATUS, 8'h00, "status write ignored");
      prev = 8'h00;
      // every code at both link speeds, answer lags one frame
      for (int k = 0; k < 26; k++) begin
         code = codes[k % 13];
         host.xfer(code, 8, (k < 13) ? 4 : 8, rx);
         chk("answer", prev, rx);
         chk("drive enable", 8'h00, {7'h00, miso_oe});
         prev = exp_resp(code, stim_ff);
         chk("irq", {7'h00, code != CMD_NO_OPERATION}, {7'h00, irq});
         rd_chk(REG_STATUS, (code == CMD_NO_OPERATION) ? 8'h00 : 8'h01, "status");
         @(posedge clk_i);
         #1 chk("irq cleared", 8'h00, {7'h00, irq});
         @(posedge clk_i);
         stim_ff <= {32'(k + 1) * 32'h9e37_79b9, 32'(k + 3) * 32'h85eb_ca6b, 32'(k + 7) * 32'hc2b2_ae35};
      end
      @(posedge clk_i);
      stim_ff[7:0] <= 8'hA5;
      host.xfer(8'h55, 8, 4, rx);
      chk("answer before unknown", prev, rx);
      rd(REG_STATUS, st);
      chk("unknown flag", 8'h02, st & 8'h02);
      rd_chk(REG_LAST_CMD, 8'h55, "last code");
      host.xfer(CMD_TIME_1A, 8, 4, rx);
      chk("unknown answer", 8'h00, rx);
      // short frame must leave the pending answer alone
      host.xfer(CMD_CONTINUITY, 5, 4, rx);
      rd(REG_STATUS, st);
      chk("frame error flag", 8'h04, st & 8'h04);
      rd_chk(REG_RESPONSE, 8'hA5, "pending answer");
      host.xfer(CMD_NO_OPERATION, 8, 4, rx);
      chk("answer after short frame", 8'hA5, rx);
      rd_chk(REG_LAST_CMD, CMD_TIME_1A, "last code after nop");
      rd_chk(REG_STATUS, 8'h00, "status after nop");
      rd_chk(REG_RESPONSE, 8'h00, "nop pending answer");
      wr(REG_MASK, 8'h00);
      host.xfer(CMD_CURR_LIMIT, 8, 4, rx);
      chk("nop answer", 8'h00, rx);
      chk("masked irq", 8'h00, {7'h00, irq});
      wr(REG_MASK, 8'h01);
      #1 chk("irq on unmask", 8'h01, {7'h00, irq});
      rd_chk(REG_STATUS, 8'h01, "masked status");
      results();
   end
endmodule
